// file: rtl/sirp_pkg.sv
// shared constants and types for the sensor register port over i2c
// assumes a single 40 MHz system clock domain for all users of the package
package sirp_pkg;

  // ---------------------------------------------------------------
  // register file geometry
  // ---------------------------------------------------------------
  localparam int        DATA_W     = 8;
  localparam int        REG_ADDR_W = 4;
  localparam int        REG_COUNT  = 16;
  localparam int        ADDR_W     = 7;
  localparam int        SYNC_W     = 9;

  // ---------------------------------------------------------------
  // event flag register at address zero
  // ---------------------------------------------------------------
  localparam logic [REG_ADDR_W-1:0] FLAGS_ADDR  = 4'h0;
  localparam logic [DATA_W-1:0]     FLAG_MASK   = 8'hcf;
  localparam logic [DATA_W-1:0]     FLAG_RESET  = 8'h00;
  localparam int                    BIT_ZORIENT = 7;
  localparam int                    BIT_XYORIENT = 6;
  localparam int                    BIT_NEGY    = 3;
  localparam int                    BIT_POSY    = 2;
  localparam int                    BIT_NEGX    = 1;
  localparam int                    BIT_POSX    = 0;

  // ---------------------------------------------------------------
  // byte framing
  // ---------------------------------------------------------------
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_FULL = 4'h8;

  // nine states need four bits of state code
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_TX_NEXT, ST_IGNORE
  } sirp_state_e;

endpackage

// file: rtl/sirp_reg_if.sv
// access strobes between the i2c engine and the user register storage
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface sirp_reg_if;
  logic                             wrEn;
  logic                             rdEn;
  logic [sirp_pkg::REG_ADDR_W-1:0] addr;
  logic [sirp_pkg::DATA_W-1:0]     wdata;
  logic [sirp_pkg::DATA_W-1:0]     rdata;

  modport ctrl (output wrEn, output rdEn, output addr, output wdata, input rdata);
  modport mem  (input wrEn, input rdEn, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// file: rtl/sirp_sync.sv
// two-flop synchroniser for a bundle of asynchronous levels
// assumes each bit is an independent level; no word coherence is given
`timescale 1ns/1ps
`default_nettype none
module sirp_sync #(
  parameter int        WIDTH = 2,
  parameter logic      INIT  = 1'b1
) (
  // system
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  if (WIDTH < 1) begin : g_chk
    $error("sirp_sync needs WIDTH of at least one");
  end

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta <= {WIDTH{INIT}};
      q    <= {WIDTH{INIT}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// file: rtl/sirp_regfile.sv
// storage for the general user registers, read data registered
// assumes the controller suppresses writes to the flag address itself
`timescale 1ns/1ps
`default_nettype none
module sirp_regfile #(
  parameter int DEPTH = sirp_pkg::REG_COUNT
) (
  // system
  input  wire logic clk,
  input  wire logic sys_rst,
  // access
  sirp_reg_if.mem   port
);
  logic [sirp_pkg::DATA_W-1:0] mem [DEPTH];

  if (DEPTH != (1 << sirp_pkg::REG_ADDR_W)) begin : g_chk
    $error("sirp_regfile depth must match the address counter range");
  end

  // ---------------------------------------------------------------
  // per-entry storage
  // ---------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        mem[i] <= '0;
      end else if (port.wrEn && (port.addr == sirp_pkg::REG_ADDR_W'(i))) begin
        mem[i] <= port.wdata;
      end
    end
  end

  // read data holds until the next read request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port.rdata <= '0;
    end else if (port.rdEn) begin
      port.rdata <= mem[port.addr];
    end
  end
endmodule
`default_nettype wire

// file: rtl/sirp_i2c_slave.sv
// i2c slave port to the sixteen user registers of the sensor
// assumes scl, sda and the address straps are asynchronous pins and eventSet
// comes from detection logic on clk; the pad resolves sda from sdaOe
`timescale 1ns/1ps
`default_nettype none
module sirp_i2c_slave (
  // system
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // i2c pins
  input  wire logic                          sclIn,
  input  wire logic                          sdaIn,
  output logic                               sdaOut,
  output logic                               sdaOe,
  // configuration
  input  wire logic [sirp_pkg::ADDR_W-1:0]   slaveAddr,
  // event sources and flags
  input  wire logic [sirp_pkg::DATA_W-1:0]   eventSet,
  output logic      [sirp_pkg::DATA_W-1:0]   eventFlags
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  sirp_reg_if regPort ();

  logic [sirp_pkg::SYNC_W-1:0]     syncOut;
  logic                            sclS;
  logic                            sdaS;
  logic [sirp_pkg::ADDR_W-1:0]     addrS;
  logic                            sclD;
  logic                            sdaD;
  logic                            sclRise;
  logic                            sclFall;
  logic                            startCond;
  logic                            stopCond;
  sirp_pkg::sirp_state_e           state;
  logic [3:0]                      bitCnt;
  logic [sirp_pkg::DATA_W-1:0]     rxShift;
  logic [sirp_pkg::DATA_W-1:0]     txShift;
  logic                            rw;
  logic                            firstData;
  logic [sirp_pkg::REG_ADDR_W-1:0] addrCnt;
  logic                            zeroSel;
  logic [sirp_pkg::DATA_W-1:0]     clearReg;
  logic [sirp_pkg::DATA_W-1:0]     txLoad;
  logic                            addrMatch;
  logic                            rxByteDone;
  logic                            loadAddr;
  logic                            wrData;
  logic                            txByteDone;
  logic                            masterAck;
  logic                            rdReq;

  // ---------------------------------------------------------------
  // pin sampling and bus conditions
  // ---------------------------------------------------------------
  sirp_sync #(
    .WIDTH (sirp_pkg::SYNC_W),
    .INIT  (1'b1)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       ({slaveAddr, sdaIn, sclIn}),
    .q       (syncOut)
  );

  assign sclS  = syncOut[0];
  assign sdaS  = syncOut[1];
  assign addrS = syncOut[sirp_pkg::SYNC_W-1:2];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclD <= 1'b1;
      sdaD <= 1'b1;
    end else begin
      sclD <= sclS;
      sdaD <= sdaS;
    end
  end

  // scl is sampled, never driven; 40 MHz gives ample margin for fast mode
  assign sclRise   = sclS && !sclD;
  assign sclFall   = !sclS && sclD;
  assign startCond = sclS && sclD && sdaD && !sdaS;
  assign stopCond  = sclS && sclD && !sdaD && sdaS;

  // ---------------------------------------------------------------
  // transfer events
  // ---------------------------------------------------------------
  assign addrMatch  = (state == sirp_pkg::ST_ADDR) && sclFall && (bitCnt == sirp_pkg::BIT_FULL)
                      && (rxShift[7:1] == addrS);
  assign rxByteDone = (state == sirp_pkg::ST_RX) && sclFall && (bitCnt == sirp_pkg::BIT_FULL);
  assign loadAddr   = rxByteDone && firstData;
  assign wrData     = rxByteDone && !firstData;
  assign txByteDone = (state == sirp_pkg::ST_TX) && sclFall && (bitCnt == sirp_pkg::BIT_LAST);
  assign masterAck  = (state == sirp_pkg::ST_TX_ACK) && sclRise && !sdaS;
  // fetch at address ack or after each master ack, well before the next fall
  assign rdReq      = (addrMatch && rxShift[0]) || masterAck;

  assign regPort.rdEn  = rdReq;
  assign regPort.wrEn  = wrData && (addrCnt != sirp_pkg::FLAGS_ADDR);
  assign regPort.addr  = addrCnt;
  assign regPort.wdata = rxShift;

  // register zero reads the live flags, others the stored bytes
  assign txLoad = zeroSel ? (eventFlags & sirp_pkg::FLAG_MASK) : regPort.rdata;

  sirp_regfile #(
    .DEPTH (sirp_pkg::REG_COUNT)
  ) u_regs (
    .clk     (clk),
    .sys_rst (sys_rst),
    .port    (regPort.mem)
  );

  // ---------------------------------------------------------------
  // protocol engine
  // ---------------------------------------------------------------
  assign sdaOut = 1'b0;  // open drain: only ever pulls low

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state     <= sirp_pkg::ST_IDLE;
      bitCnt    <= '0;
      rxShift   <= '0;
      txShift   <= '0;
      rw        <= 1'b0;
      firstData <= 1'b1;
      sdaOe     <= 1'b0;
    end else if (startCond) begin
      state     <= sirp_pkg::ST_ADDR;
      bitCnt    <= '0;
      firstData <= 1'b1;
      sdaOe     <= 1'b0;
    end else if (stopCond) begin
      state     <= sirp_pkg::ST_IDLE;
      sdaOe     <= 1'b0;
    end else begin
      case (state)
        sirp_pkg::ST_ADDR, sirp_pkg::ST_RX: begin
          if (sclRise) begin
            rxShift <= {rxShift[6:0], sdaS};
            bitCnt  <= bitCnt + 4'h1;
          end else if (sclFall && (bitCnt == sirp_pkg::BIT_FULL)) begin
            if (state == sirp_pkg::ST_RX) begin
              sdaOe     <= 1'b1;
              firstData <= 1'b0;
              state     <= sirp_pkg::ST_RX_ACK;
            end else if (addrMatch) begin
              sdaOe <= 1'b1;
              rw    <= rxShift[0];
              state <= sirp_pkg::ST_ADDR_ACK;
            end else begin
              state <= sirp_pkg::ST_IGNORE;
            end
          end
        end
        sirp_pkg::ST_ADDR_ACK: begin
          if (sclFall) begin
            bitCnt <= '0;
            if (rw) begin
              txShift <= txLoad;
              sdaOe   <= !txLoad[7];
              state   <= sirp_pkg::ST_TX;
            end else begin
              sdaOe <= 1'b0;
              state <= sirp_pkg::ST_RX;
            end
          end
        end
        sirp_pkg::ST_RX_ACK: begin
          if (sclFall) begin
            sdaOe  <= 1'b0;
            bitCnt <= '0;
            state  <= sirp_pkg::ST_RX;
          end
        end
        sirp_pkg::ST_TX: begin
          if (sclFall) begin
            if (bitCnt == sirp_pkg::BIT_LAST) begin
              sdaOe <= 1'b0;
              state <= sirp_pkg::ST_TX_ACK;
            end else begin
              txShift <= {txShift[6:0], 1'b0};
              sdaOe   <= !txShift[6];
              bitCnt  <= bitCnt + 4'h1;
            end
          end
        end
        sirp_pkg::ST_TX_ACK: begin
          if (sclRise) begin
            // a nack marks the last byte: stay off the line until start or stop
            state <= sdaS ? sirp_pkg::ST_IGNORE : sirp_pkg::ST_TX_NEXT;
          end
        end
        sirp_pkg::ST_TX_NEXT: begin
          if (sclFall) begin
            txShift <= txLoad;
            sdaOe   <= !txLoad[7];
            bitCnt  <= '0;
            state   <= sirp_pkg::ST_TX;
          end
        end
        sirp_pkg::ST_IDLE, sirp_pkg::ST_IGNORE: begin
          sdaOe <= 1'b0;
        end
        default: begin
          state <= sirp_pkg::ST_IDLE;
          sdaOe <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register address counter
  // ---------------------------------------------------------------
  // four bits wide, so it wraps from 0x0f back to 0x00
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addrCnt <= sirp_pkg::FLAGS_ADDR;
    end else if (loadAddr) begin
      addrCnt <= rxShift[sirp_pkg::REG_ADDR_W-1:0];
    end else if (wrData || txByteDone) begin
      addrCnt <= addrCnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      zeroSel <= 1'b0;
    end else if (rdReq) begin
      zeroSel <= (addrCnt == sirp_pkg::FLAGS_ADDR);
    end
  end

  // ---------------------------------------------------------------
  // event flags and their self-clearing clear register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clearReg <= '0;
    end else if (wrData && (addrCnt == sirp_pkg::FLAGS_ADDR)) begin
      clearReg <= rxShift & sirp_pkg::FLAG_MASK;
    end else begin
      clearReg <= '0;
    end
  end

  // a new event in the clearing cycle survives: set wins over clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eventFlags <= sirp_pkg::FLAG_RESET;
    end else begin
      eventFlags <= ((eventFlags & ~clearReg) | eventSet) & sirp_pkg::FLAG_MASK;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_sda_scl_low: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(sdaOe) |-> ($past(sclFall) || $past(startCond) || $past(stopCond)))
    else $error("sda drive changed outside scl low");

  a_start_restart: assert property (@(posedge clk) disable iff (sys_rst)
    startCond |=> (state == sirp_pkg::ST_ADDR) && (bitCnt == 4'h0) && !sdaOe)
    else $error("start did not restart address decoding");

  a_idle_released: assert property (@(posedge clk) disable iff (sys_rst)
    stopCond |=> (state == sirp_pkg::ST_IDLE) ##1 !sdaOe)
    else $error("sda held after stop");

  a_tx_msb_first: assert property (@(posedge clk) disable iff (sys_rst)
    (state == sirp_pkg::ST_TX) |-> (sdaOe == !txShift[7]))
    else $error("transmit bit not msb of shift register");

  a_rx_ack_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (state == sirp_pkg::ST_RX_ACK) && !sclFall && !startCond && !stopCond |=> sdaOe)
    else $error("acknowledge released early");

  a_nack_release: assert property (@(posedge clk) disable iff (sys_rst)
    (state == sirp_pkg::ST_TX_ACK) && sclRise && sdaS && !startCond && !stopCond
    |=> (state == sirp_pkg::ST_IGNORE) ##1 !sdaOe)
    else $error("sda not released after master nack");

  a_addr_ack: assert property (@(posedge clk) disable iff (sys_rst)
    addrMatch && !startCond && !stopCond |=> sdaOe && (state == sirp_pkg::ST_ADDR_ACK))
    else $error("matching address not acknowledged");

  a_mismatch_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    (state == sirp_pkg::ST_IGNORE) |=> !sdaOe)
    else $error("drove sda after address mismatch");

  a_wr_advance: assert property (@(posedge clk) disable iff (sys_rst)
    wrData |=> (addrCnt == ($past(addrCnt) + 1'b1)))
    else $error("address counter did not advance after write");

  a_rd_advance: assert property (@(posedge clk) disable iff (sys_rst)
    txByteDone |=> (addrCnt == ($past(addrCnt) + 1'b1)))
    else $error("address counter did not advance after read byte");

  a_addr_load: assert property (@(posedge clk) disable iff (sys_rst)
    loadAddr |=> (addrCnt == $past(rxShift[3:0])))
    else $error("first written byte not loaded into counter");

  a_zero_no_store: assert property (@(posedge clk) disable iff (sys_rst)
    regPort.wrEn |-> (regPort.addr != sirp_pkg::FLAGS_ADDR))
    else $error("write reached storage at flag address");

  a_clear_flag: assert property (@(posedge clk) disable iff (sys_rst)
    (wrData && (addrCnt == sirp_pkg::FLAGS_ADDR)) ##1 (eventSet == 8'h00)
    |=> ((eventFlags & $past(clearReg)) == 8'h00) ##1 (clearReg == 8'h00))
    else $error("clear did not remove flag or did not self-clear");

  a_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
    ((eventSet & sirp_pkg::FLAG_MASK) != 8'h00)
    |=> ((eventFlags & $past(eventSet & sirp_pkg::FLAG_MASK))
         == $past(eventSet & sirp_pkg::FLAG_MASK)))
    else $error("event lost");

  a_flag_reserved: assert property (@(posedge clk) disable iff (sys_rst)
    (eventFlags & ~sirp_pkg::FLAG_MASK) == 8'h00)
    else $error("reserved flag bits not zero");

  a_open_drain: assert property (@(posedge clk) disable iff (sys_rst)
    sdaOut == 1'b0)
    else $error("sda driven high");
endmodule
`default_nettype wire

// file: tb/sirp_i2c_master.sv
// i2c bus master model: makes scl and pulls sda low through open drain
// assumes sda is resolved outside as a pulled-up wired line
`timescale 1ns/1ps
`default_nettype none
module sirp_i2c_master (
  // bus lines
  output var logic scl,
  output var logic sdaPull,
  input  wire logic sda
);
  // ------------------------------------------------------------
  // bus primitives: 200 ns bit, scl low 125 ns
  // ------------------------------------------------------------
  // the long low phase leaves room for the slave's synchroniser delay
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end

  // both lines are low together for well under a bit time
  task automatic startCond();
    #25 sdaPull = 1'b0;
    #100 scl = 1'b1;
    #50 sdaPull = 1'b1;
    #50 scl = 1'b0;
  endtask

  task automatic stopCond();
    #25 sdaPull = 1'b1;
    #100 scl = 1'b1;
    #50 sdaPull = 1'b0;
    #200;
  endtask

  task automatic writeByte(input logic [7:0] b, output logic ack);
    logic a1;
    for (int i = 7; i >= 0; i--) begin
      #25 sdaPull = !b[i];
      #100 scl = 1'b1;
      #75 scl = 1'b0;
    end
    #25 sdaPull = 1'b0;
    #100 scl = 1'b1;
    #1 a1 = sda;
    #73 ack = !a1 && !sda;
    #1 scl = 1'b0;
  endtask

  task automatic readByte(input logic ackIt, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #25 sdaPull = 1'b0;
      #100 scl = 1'b1;
      #74 b[i] = sda;
      #1 scl = 1'b0;
    end
    #25 sdaPull = ackIt;
    #100 scl = 1'b1;
    #75 scl = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb/sirp_i2c_slave_bench.sv
// self-checking bench for the i2c register port against a master model
// assumes package, interface and design modules are compiled first
`timescale 1ns/1ps
`default_nettype none
module sirp_i2c_slave_bench;
  // ------------------------------------------------------------
  // wiring
  // ------------------------------------------------------------
  localparam logic [6:0] OWN_A = 7'h15;
  localparam logic [6:0] ALT_A = 7'h2a;
  logic       clk;
  logic       sysRst;
  logic       scl;
  logic       sdaPull;
  wire logic  sda;
  logic       sdaOut;
  logic       sdaOe;
  logic [6:0] slaveAddr;
  logic [6:0] ownAddr;
  logic [7:0] eventSet;
  logic [7:0] eventFlags;
  logic       prevOe;
  logic       prevScl;
  logic       oeSeen;
  int         errorCnt;
  int         samplesChecked;
  int         cycles;

  assign sda = !(sdaOe | sdaPull);

  sirp_i2c_master master (.scl(scl), .sdaPull(sdaPull), .sda(sda));

  sirp_i2c_slave DUT (
    .clk(clk), .sys_rst(sysRst), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .slaveAddr(slaveAddr), .eventSet(eventSet), .eventFlags(eventFlags)
  );

  // ------------------------------------------------------------
  // checking and report
  // ------------------------------------------------------------
  task automatic checkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
    samplesChecked++;
    if (got !== exp) begin
      errorCnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic checkBit(input string what, input logic exp, input logic got);
    checkByte(what, {7'h00, exp}, {7'h00, got});
  endtask

  task automatic finalReport();
    $display("comparisons %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = !clk;
  end

  // pin watch; sdaOe may only move while scl has been low
  always @(negedge clk) begin
    cycles++;
    if (!sysRst) begin
      if (sdaOut !== 1'b0) checkBit("sdaOut", 1'b0, sdaOut);
      if (prevScl && scl) checkBit("sdaOe steady in scl high", prevOe, sdaOe);
      if (sdaOe !== 1'b0) oeSeen = 1'b1;
    end
    prevOe = sdaOe;
    prevScl = scl;
    if (cycles == 20000) begin
      errorCnt++;
      finalReport();
    end
  end

  // ------------------------------------------------------------
  // bus helpers
  // ------------------------------------------------------------
  task automatic sendByte(input logic [7:0] b, input logic expAck, input string what);
    logic ack;
    master.writeByte(b, ack);
    checkBit(what, expAck, ack);
  endtask

  task automatic openAt(input logic [7:0] r);
    master.startCond();
    sendByte({ownAddr, 1'b0}, 1'b1, "addr w ack");
    sendByte(r, 1'b1, "reg addr ack");
  endtask

  task automatic regWrite(input logic [7:0] r, input logic [7:0] d);
    openAt(r);
    sendByte(d, 1'b1, "data ack");
    master.stopCond();
  endtask

  // a preceding unfinished write makes the first start a repeated one
  task automatic readPair(input logic [7:0] r, input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] b;
    openAt(r);
    master.startCond();
    sendByte({ownAddr, 1'b1}, 1'b1, "addr r ack");
    master.readByte(1'b1, b);
    checkByte("read first", e0, b);
    master.readByte(1'b0, b);
    checkByte("read next", e1, b);
    #150 checkBit("released after nack", 1'b0, sdaOe);
    master.stopCond();
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic testReset();
    checkBit("sdaOe idle", 1'b0, sdaOe);
    checkByte("flags reset", 8'h00, eventFlags);
  endtask

  task automatic testWriteWrap();
    openAt(8'h0e);
    sendByte(8'ha5, 1'b1, "data 14");
    sendByte(8'h3c, 1'b1, "data 15");
    sendByte(8'hff, 1'b1, "data wrap");
    master.stopCond();
    readPair(8'h0e, 8'ha5, 8'h3c);
    readPair(8'h0f, 8'h3c, 8'h00);
  endtask

  task automatic testMismatch();
    oeSeen = 1'b0;
    master.startCond();
    sendByte({ALT_A, 1'b0}, 1'b0, "foreign addr nack");
    sendByte(8'h02, 1'b0, "ignored byte");
    master.stopCond();
    checkBit("sda untouched", 1'b0, oeSeen);
    @(negedge clk) slaveAddr = ALT_A;
    ownAddr = ALT_A;
    regWrite(8'h07, 8'h96);
    readPair(8'h07, 8'h96, 8'h00);
    @(negedge clk) slaveAddr = OWN_A;
    ownAddr = OWN_A;
  endtask

  task automatic testFlags();
    @(negedge clk) eventSet = 8'hff;
    @(negedge clk) eventSet = 8'h00;
    checkByte("flags set", 8'hcf, eventFlags);
    regWrite(8'h00, 8'h00);
    checkByte("zero clear", 8'hcf, eventFlags);
    regWrite(8'h00, 8'h41);
    checkByte("partial clear", 8'h8e, eventFlags);
    regWrite(8'h00, 8'h30);
    checkByte("unused clear", 8'h8e, eventFlags);
    readPair(8'h00, 8'h8e, 8'h00);
    regWrite(8'h00, 8'h8e);
    checkByte("full clear", 8'h00, eventFlags);
  endtask

  task automatic testRestart();
    openAt(8'h03);
    sendByte(8'h11, 1'b1, "data 3");
    sendByte(8'h22, 1'b1, "data 4");
    readPair(8'h03, 8'h11, 8'h22);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    sysRst = 1'b1;
    eventSet = 8'h00;
    slaveAddr = OWN_A;
    ownAddr = OWN_A;
    oeSeen = 1'b0;
    errorCnt = 0;
    samplesChecked = 0;
    cycles = 0;
    repeat (8) @(negedge clk);
    sysRst = 1'b0;
    repeat (4) @(negedge clk);
    testReset();
    testWriteWrap();
    testMismatch();
    testFlags();
    testRestart();
    finalReport();
  end
endmodule
`default_nettype wire
